// File: hdl/uart_async_tx.sv
// Our own choices: the register offsets and register access over AHB-Lite.
`timescale 1ns/1ps
`default_nettype none
module uart_async_tx
   import uart_tx_pkg::*;
   #(parameter int DIV_W = 16)
   (
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic             hresp,
   output logic [31:0]      hrdata,
   output logic             tx_out,
   output logic             tx_oe
   );

   ctrl_t            ctrl_reg;
   ctrl_t            ctrl_next;
   logic [DIV_W-1:0] baud_reg;
   logic [DIV_W-1:0] baud_next;
   hold_t            hold_reg;
   hold_t            hold_next;
   logic             hold_full_reg;
   logic             hold_full_next;
   dphase_t          dph_reg;
   dphase_t          dph_next;
   logic [31:0]      hrdata_reg;
   logic [31:0]      hrdata_next;
   logic             tx_out_reg;
   logic             tx_out_next;
   logic             tx_oe_reg;
   logic             tx_oe_next;
   logic             active;
   logic             tick;
   logic             take;
   logic             busy;
   logic             line;
   logic             transmit_buffer_empty_flag;
   logic             shifter_empty;
   logic             addr_take;
   logic             wr;

   // the shift register has no address of its own
   function automatic reg_id_t decode(input logic [31:0] a);
      reg_id_t r;
      r = REG_NONE;
      if (a[31:8] == 24'h000000)
      begin
         case (a[7:0])
            CTRL_OFS: r = REG_CTRL;
            STAT_OFS: r = REG_STAT;
            HOLD_OFS: r = REG_HOLD;
            BAUD_OFS: r = REG_BAUD;
            default:  r = REG_NONE; // RL9
         endcase
      end
      return r;
   endfunction : decode

   function automatic logic [31:0] rd_value(input reg_id_t id);
      logic [31:0] v;
      v = 32'h00000000;
      case (id)
         REG_CTRL: v[7:0] = ctrl_reg;
         REG_STAT:
         begin
            v[STAT_TXE_POS] = transmit_buffer_empty_flag;
            v[STAT_SHE_POS] = shifter_empty;
         end
         REG_BAUD: v[DIV_W-1:0] = baud_reg;
         default:  v = 32'h00000000;
      endcase
      return v;
   endfunction : rd_value

   // bus slave: writes have no wait state, reads one, to let the
   // read data come from a flip-flop after any earlier write landed
   always_comb
   begin
      dph_next = dph_reg;
      hrdata_next = hrdata_reg;
      addr_take = hsel && htrans[1] && hready;
      if (dph_reg.valid && dph_reg.rd_wait)
      begin
         hrdata_next = rd_value(dph_reg.id);
         dph_next.rd_wait = 1'b0;
      end
      if (hready)
      begin
         dph_next.valid = addr_take;
         dph_next.write = hwrite;
         dph_next.rd_wait = addr_take && !hwrite;
         dph_next.id = decode(haddr);
      end
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         dph_reg <= '{valid: 1'b0, write: 1'b0, rd_wait: 1'b0, id: REG_NONE};
         hrdata_reg <= 32'h00000000;
      end
      else
      begin
         dph_reg <= dph_next;
         hrdata_reg <= hrdata_next;
      end
   end

   assign hreadyout = !(dph_reg.valid && dph_reg.rd_wait);
   assign hresp = HRESP_OKAY;
   assign hrdata = hrdata_reg;
   assign wr = dph_reg.valid && dph_reg.write;

   // register file and holding buffer
   always_comb
   begin
      ctrl_next = ctrl_reg;
      baud_next = baud_reg;
      hold_next = hold_reg;
      hold_full_next = hold_full_reg;
      if (take)
      begin
         hold_full_next = 1'b0; // RL13
         // break request is spent once its frame is in the shifter
         if (hold_reg.brk)
            ctrl_next.send_break = 1'b0; // RL17
      end
      if (wr)
      begin
         case (dph_reg.id)
            REG_CTRL: ctrl_next = ctrl_t'(hwdata[7:0]);
            REG_HOLD:
            begin
               // a write while a character waits is dropped, not queued;
               // the slot is free again on the edge that loads the shifter
               if (!hold_full_reg || take)
               begin
                  hold_next.brk = ctrl_reg.send_break;
                  hold_next.data = {ctrl_reg.ninth_data_bit, hwdata[7:0]};
                  hold_full_next = 1'b1; // RL16 RL13
               end
            end
            REG_BAUD: baud_next = hwdata[DIV_W-1:0]; // RL7
            default: ;
         endcase
      end
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         ctrl_reg <= ctrl_t'(CTRL_RST);
         baud_reg <= BAUD_RST[DIV_W-1:0];
         hold_reg <= '{brk: 1'b0, data: 9'h000};
         hold_full_reg <= 1'b0;
      end
      else
      begin
         ctrl_reg <= ctrl_next;
         baud_reg <= baud_next;
         hold_reg <= hold_next;
         hold_full_reg <= hold_full_next;
      end
   end

   always_comb
   begin
      active = ctrl_reg.tx_enable && !ctrl_reg.clocked_mode_select
               && ctrl_reg.serial_port_enable; // RL10
      transmit_buffer_empty_flag = ctrl_reg.tx_enable && !(hold_full_reg && busy); // RL12 RL18
      shifter_empty = !busy; // RL19
   end

   uart_baud_gen #(.DIV_W(DIV_W)) u_baud (
      .hclk    (hclk),
      .hresetn (hresetn),
      .restart (take),
      .sixteen (ctrl_reg.brg16),
      .divisor (baud_reg),
      .tick    (tick)
   ); // RL5 RL7

   uart_tx_shifter u_shift (
      .hclk       (hclk),
      .hresetn    (hresetn),
      .enable     (active),
      .tick       (tick),
      .nine       (ctrl_reg.nine_bit_select),
      .load_valid (hold_full_reg),
      .load_data  (hold_reg),
      .load_take  (take),
      .busy       (busy),
      .line       (line)
   ); // RL14 RL22

   // pin stage: one register so the pad sees a clean flop output
   always_comb
   begin
      tx_oe_next = ctrl_reg.serial_port_enable
                   && ctrl_reg.tx_enable; // RL11 RL15
      tx_out_next = line ^ ctrl_reg.polarity_invert; // RL21 RL1
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         tx_oe_reg <= 1'b0;
         tx_out_reg <= 1'b1;
      end
      else
      begin
         tx_oe_reg <= tx_oe_next;
         tx_out_reg <= tx_out_next;
      end
   end

   assign tx_oe = tx_oe_reg;
   assign tx_out = tx_out_reg;

   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   property p_take_at_once;
      hold_full_reg && active && !busy |-> take;
   endproperty
   a_take_at_once: assert property (p_take_at_once) // RL13
      else $error("idle shifter did not take waiting character");

   property p_transmit_buffer_empty_flag_low;
      ctrl_reg.tx_enable && !transmit_buffer_empty_flag |-> busy && hold_full_reg;
   endproperty
   a_transmit_buffer_empty_flag_low: assert property (p_transmit_buffer_empty_flag_low) // RL18
      else $error("buffer-empty flag low without a waiting character");

   property p_transmit_buffer_empty_flag_enable;
      $rose(ctrl_reg.tx_enable) |-> transmit_buffer_empty_flag;
   endproperty
   a_transmit_buffer_empty_flag_enable: assert property (p_transmit_buffer_empty_flag_enable) // RL12
      else $error("buffer-empty flag not set on enable");

   property p_shifter_flag;
      take |=> !shifter_empty;
   endproperty
   a_shifter_flag: assert property (p_shifter_flag) // RL19
      else $error("shifter-empty flag still set after load");

   property p_hold_keep;
      hold_full_reg && !take |=> hold_full_reg && hold_reg == $past(hold_reg);
   endproperty
   a_hold_keep: assert property (p_hold_keep) // RL16
      else $error("waiting character changed before load");

   sequence s_load;
      take && !hold_reg.brk;
   endsequence
   property p_pin_start;
      s_load ##1 active |=> tx_oe && tx_out == ctrl_reg.polarity_invert;
   endproperty
   a_pin_start: assert property (p_pin_start) // RL21
      else $error("start bit not seen on the pin");

   sequence s_rd_addr;
      addr_take && !hwrite;
   endsequence

   property p_write_ready;
      addr_take && hwrite |=> hreadyout;
   endproperty
   a_write_ready: assert property (p_write_ready) // RL13
      else $error("write data phase was stretched");

   property p_read_wait;
      s_rd_addr |=> !hreadyout ##1 hreadyout;
   endproperty
   a_read_wait: assert property (p_read_wait) // RL9
      else $error("read data phase not exactly one wait state");

   property p_unmapped_zero;
      s_rd_addr ##0 (decode(haddr) == REG_NONE) |=> ##1 hrdata == '0;
   endproperty
   a_unmapped_zero: assert property (p_unmapped_zero) // RL9
      else $error("unmapped read returned nonzero data");

   property p_oe_on;
      ctrl_reg.serial_port_enable && ctrl_reg.tx_enable |=> tx_oe;
   endproperty
   a_oe_on: assert property (p_oe_on) // RL11
      else $error("pin not driven with port and transmitter enabled");

   property p_oe_off;
      !ctrl_reg.tx_enable |=> !tx_oe;
   endproperty
   a_oe_off: assert property (p_oe_off) // RL15
      else $error("pin still driven with transmitter disabled");

   property p_break_spent;
      take && hold_reg.brk && !(wr && dph_reg.id == REG_CTRL)
         |=> !ctrl_reg.send_break;
   endproperty
   a_break_spent: assert property (p_break_spent) // RL17
      else $error("break request not spent after its frame loaded");

   property p_hold_capture;
      wr && dph_reg.id == REG_HOLD && (!hold_full_reg || take)
         |=> hold_full_reg && hold_reg.data[7:0] == $past(hwdata[7:0]);
   endproperty
   a_hold_capture: assert property (p_hold_capture) // RL13
      else $error("accepted character not held in the buffer");

   property p_inactive_wait;
      hold_full_reg && !active |=> hold_full_reg;
   endproperty
   a_inactive_wait: assert property (p_inactive_wait) // RL10
      else $error("character left the buffer while inactive");

   property p_transmit_buffer_empty_flag_full;
      busy && hold_full_reg |-> !transmit_buffer_empty_flag;
   endproperty
   a_transmit_buffer_empty_flag_full: assert property (p_transmit_buffer_empty_flag_full) // RL18
      else $error("buffer-empty flag set while a character waits");

endmodule : uart_async_tx
`default_nettype wire

// File: hdl/uart_tx_pkg.sv
// Notes on behaviour
// RL1: the line rests at mark whenever no character is being sent.
// RL2: a frame is one start bit, eight or nine data bits, then stop bits.
// RL3: the start bit is always space and every stop bit always mark.
// RL4: each bit stays on the line for exactly one bit period, no return.
// RL5: bit timing comes from a divider switchable between 8 and 16 bits.
// RL6: data bits go out least significant bit first.
// RL7: format and baud setting are shared with the receiver side.
// RL8: no parity logic; software supplies parity as the ninth data bit.
// RL9: the shifter has no software access; it loads only from the buffer.
// RL10: sending runs only with tx enabled, async mode and port enabled.
// RL11: enabling the serial port turns the transmit pin into an output.
// RL12: enabling the transmitter sets the buffer-empty flag.
// RL13: a buffer write starts sending; an idle shifter takes it at once.
// RL14: a waiting character loads right after the stop bit, start follows.
// RL15: a disabled transmitter releases its pin for general use.
// RL16: exactly one character of buffering sits ahead of the shifter.
// RL17: a break of thirteen space bit periods can be sent.
// RL18: buffer-empty clears only while shifter busy and a character waits; the code also holds it clear while tx_enable is clear.
// RL19: shifter-empty clears on load and stays clear until all bits are out.
// RL20: software writes the ninth bit before the low eight bits.
// RL21: polarity invert set makes idle and data low-true; clear is high-true.
// RL22: the bit counter advances on baud ticks; idle after last stop bit.
package uart_tx_pkg;

   localparam logic [7:0]  CTRL_OFS      = 8'h00;
   localparam logic [7:0]  STAT_OFS      = 8'h04;
   localparam logic [7:0]  HOLD_OFS      = 8'h08;
   localparam logic [7:0]  BAUD_OFS      = 8'h0C;
   localparam logic [7:0]  CTRL_RST      = 8'h00;
   localparam logic [15:0] BAUD_RST      = 16'h0019;
   localparam int          STAT_TXE_POS  = 0;
   localparam int          STAT_SHE_POS  = 1;
   localparam int          FRAME_W       = 14;
   localparam int          BREAK_BITS    = 13;
   localparam logic [3:0]  FRAME8_LEN    = 4'hA;
   localparam logic [3:0]  FRAME9_LEN    = 4'hB;
   localparam logic [3:0]  BREAK_LEN     = 4'hE;
   localparam logic        HRESP_OKAY    = 1'b0;

   // bit 0 is tx_enable, bit 7 is send_break
   typedef struct packed {
      logic send_break;
      logic brg16;
      logic polarity_invert;
      logic ninth_data_bit;
      logic nine_bit_select;
      logic serial_port_enable;
      logic clocked_mode_select;
      logic tx_enable;
   } ctrl_t;

   typedef struct packed {
      logic       brk;
      logic [8:0] data;
   } hold_t;

   typedef enum logic [2:0] {
      REG_CTRL = 3'b000,
      REG_STAT = 3'b001,
      REG_HOLD = 3'b010,
      REG_BAUD = 3'b011,
      REG_NONE = 3'b100
   } reg_id_t;

   typedef struct packed {
      logic    valid;
      logic    write;
      logic    rd_wait;
      reg_id_t id;
   } dphase_t;

endpackage : uart_tx_pkg

// File: hdl/uart_baud_gen.sv
`timescale 1ns/1ps
`default_nettype none
module uart_baud_gen
   import uart_tx_pkg::*;
   #(parameter int DIV_W = 16)
   (
   input  wire logic             hclk,
   input  wire logic             hresetn,
   input  wire logic             restart,
   input  wire logic             sixteen,
   input  wire logic [DIV_W-1:0] divisor,
   output logic                  tick
   );

   logic [DIV_W-1:0] cnt_reg;
   logic [DIV_W-1:0] cnt_next;
   logic [DIV_W-1:0] lim;

   always_comb
   begin
      lim = sixteen ? divisor : {{(DIV_W-8){1'b0}}, divisor[7:0]}; // RL5
      tick = (cnt_reg == '0);
      if (restart || tick)
         cnt_next = lim;
      else
         cnt_next = cnt_reg - 1'b1;
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         cnt_reg <= '0;
      else
         cnt_reg <= cnt_next;
   end

   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   property p_tick_gap;
      tick && !restart && lim != '0 |=> !tick;
   endproperty
   a_tick_gap: assert property (p_tick_gap) // RL4
      else $error("baud ticks closer than the divisor allows");

endmodule : uart_baud_gen
`default_nettype wire

// File: hdl/uart_tx_shifter.sv
`timescale 1ns/1ps
`default_nettype none
module uart_tx_shifter
   import uart_tx_pkg::*;
   (
   input  wire logic  hclk,
   input  wire logic  hresetn,
   input  wire logic  enable,
   input  wire logic  tick,
   input  wire logic  nine,
   input  wire logic  load_valid,
   input  wire hold_t load_data,
   output logic       load_take,
   output logic       busy,
   output logic       line
   );

   logic [FRAME_W-1:0] sh_reg;
   logic [FRAME_W-1:0] sh_next;
   logic [3:0]         cnt_reg;
   logic [3:0]         cnt_next;
   logic [FRAME_W-1:0] frame;
   logic [3:0]         len;
   logic               last;

   always_comb
   begin
      busy = (cnt_reg != 4'h0);
      last = tick && (cnt_reg == 4'h1);
      // the next frame starts on the very tick that ends the stop bit
      load_take = enable && load_valid && (!busy || last); // RL13 RL14
      if (load_data.brk)
      begin
         frame = {1'b1, {BREAK_BITS{1'b0}}}; // RL17
         len = BREAK_LEN;
      end
      else if (nine)
      begin
         frame = {4'b1111, load_data.data, 1'b0}; // RL2 RL3 RL8
         len = FRAME9_LEN;
      end
      else
      begin
         frame = {5'b11111, load_data.data[7:0], 1'b0}; // RL2 RL3
         len = FRAME8_LEN;
      end
      sh_next = sh_reg;
      cnt_next = cnt_reg;
      if (!enable)
      begin
         sh_next = '1; // RL10
         cnt_next = 4'h0;
      end
      else if (load_take)
      begin
         sh_next = frame;
         cnt_next = len;
      end
      else if (tick && busy)
      begin
         sh_next = {1'b1, sh_reg[FRAME_W-1:1]}; // RL6 RL1
         cnt_next = cnt_reg - 4'h1; // RL22
      end
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         sh_reg <= '1;
         cnt_reg <= 4'h0;
      end
      else
      begin
         sh_reg <= sh_next;
         cnt_reg <= cnt_next;
      end
   end

   assign line = sh_reg[0]; // RL4

   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   property p_idle_mark;
      !busy |-> line;
   endproperty
   a_idle_mark: assert property (p_idle_mark) // RL1
      else $error("line not at mark while idle");

   property p_start_space;
      load_take |=> !line && busy;
   endproperty
   a_start_space: assert property (p_start_space) // RL3
      else $error("start bit not at space after load");

   property p_lsb_first;
      load_take && !load_data.brk |=> sh_reg[1] == $past(load_data.data[0]);
   endproperty
   a_lsb_first: assert property (p_lsb_first) // RL6
      else $error("first data bit is not the lsb");

   sequence s_break_load;
      load_take && load_data.brk;
   endsequence
   property p_break_space;
      s_break_load |=> !line [*8];
   endproperty
   a_break_space: assert property (p_break_space) // RL17
      else $error("break does not hold space");

   property p_disable_idle;
      !enable |=> !busy && line;
   endproperty
   a_disable_idle: assert property (p_disable_idle) // RL10
      else $error("shifter kept running while disabled");

endmodule : uart_tx_shifter
`default_nettype wire

// File: dv/serial_rx_model.sv
`timescale 1ns/1ps
`default_nettype none
module serial_rx_model
   (
   input  wire logic        hclk,
   input  wire logic        line,
   input  wire logic        invert,
   input  wire logic        nine,
   input  wire logic [15:0] bit_clocks
   );
   // listens only: the far receiver never drives the line
   logic [9:0] got[$];
   time        at[$];

   initial
   begin : rx
      logic [9:0] w;
      int         n;
      forever
      begin
         @(posedge hclk);
         if ((line ^ invert) === 1'b0)
         begin
            at.push_back($time);
            // sample mid-bit so a one-cycle skew cannot flip a bit
            repeat (bit_clocks / 2) @(posedge hclk);
            n = nine ? 10 : 9;
            w = '0;
            for (int i = 0; i < n; i++)
            begin
               repeat (bit_clocks) @(posedge hclk);
               w[i] = line ^ invert;
            end
            got.push_back({w[n-1], nine & w[8], w[7:0]});
            // a break keeps the line at space past the stop sample
            while ((line ^ invert) === 1'b0) @(posedge hclk);
         end
      end
   end
endmodule : serial_rx_model
`default_nettype wire

// File: dv/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench
   import uart_tx_pkg::*;
   ;
   logic        hclk        = 1'b0;
   logic        hresetn     = 1'b0;
   logic        hsel        = 1'b0;
   logic [31:0] haddr       = '0;
   logic [1:0]  htrans      = 2'b00;
   logic        hwrite      = 1'b0;
   logic [2:0]  hsize       = 3'b010;
   logic [31:0] hwdata      = '0;
   logic        hreadyout;
   logic        hresp;
   logic [31:0] hrdata;
   logic        tx_out;
   logic        tx_oe;
   wire         pin;
   logic [15:0] bit_clocks  = 16'h0002;
   logic        rx_inv      = 1'b0;
   logic        rx_nine     = 1'b0;
   int          error_cnt   = 0;
   int          comparisons = 0;
   logic [31:0] rd;
   time         last_t;
   time         t0;
   int          n;

   always #2 hclk = ~hclk;

   // pull-up on the pin: a released pin reads mark
   assign pin = tx_oe ? tx_out : 1'b1;

   uart_async_tx i_uart_async_tx (.hclk(hclk), .hresetn(hresetn),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
      .tx_out(tx_out), .tx_oe(tx_oe));

   serial_rx_model i_serial_rx_model (.hclk(hclk), .line(pin),
      .invert(rx_inv), .nine(rx_nine), .bit_clocks(bit_clocks));

   task automatic test_done;
      $display("errors %0d comparisons %0d", error_cnt, comparisons);
      if (error_cnt == 0 && comparisons > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : test_done

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask : check

   task automatic bus(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      hsel   <= 1'b1;
      haddr  <= {24'h0, a};
      htrans <= 2'b10;
      hwrite <= w;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'b00;
      hwdata <= w ? d : 32'h0;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask : bus

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
   endtask : wr

   task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0);
      check(rd, exp);
   endtask : rdchk

   task automatic wait_idle;
      rd = 32'h0;
      while (rd[STAT_SHE_POS] !== 1'b1) bus(1'b0, STAT_OFS, 32'h0);
      repeat (8) @(posedge hclk);
   endtask : wait_idle

   task automatic frame(input logic [9:0] exp);
      logic [9:0] w;
      w      = 'x;
      last_t = 0;
      if (i_serial_rx_model.got.size() > 0)
         w = i_serial_rx_model.got.pop_front();
      if (i_serial_rx_model.at.size() > 0)
         last_t = i_serial_rx_model.at.pop_front();
      check({22'h0, w}, {22'h0, exp});
   endtask : frame

   // polarity or break leaves junk in the receiver; let it pass
   task automatic settle;
      repeat (60) @(posedge hclk);
      i_serial_rx_model.got.delete();
      i_serial_rx_model.at.delete();
   endtask : settle

   initial
   begin
      repeat (40000) @(posedge hclk);
      error_cnt++;
      test_done;
   end

   initial
   begin
      repeat (20) @(posedge hclk);
      hresetn <= 1'b1;
      check({31'h0, tx_out}, 32'h1);
      check({31'h0, tx_oe}, 32'h0);
      rdchk(CTRL_OFS, {24'h0, CTRL_RST});
      rdchk(BAUD_OFS, {16'h0, BAUD_RST});
      rdchk(STAT_OFS, 32'h2);
      rdchk(8'h10, 32'h0);
      check({31'h0, hresp}, 32'h0);
      rdchk(HOLD_OFS, 32'h0);
      for (int k = 0; k < 2; k++)
      begin
         bit_clocks <= k ? 16'h3 : 16'h2;
         wr(BAUD_OFS, k ? 32'h2 : 32'h301);
         wr(CTRL_OFS, k ? 32'h45 : 32'h05);
         rdchk(STAT_OFS, 32'h3);
         check({31'h0, tx_oe}, 32'h1);
         wr(HOLD_OFS, 32'h3C);
         wr(HOLD_OFS, 32'h81);
         rdchk(STAT_OFS, 32'h0);
         wr(HOLD_OFS, 32'hFF);
         wait_idle;
         frame(10'h23C);
         t0 = last_t;
         frame(10'h281);
         check(32'(last_t - t0), 32'(40 * (k + 2)));
         check(i_serial_rx_model.got.size(), 32'h0);
      end
      rx_nine <= 1'b1;
      for (int b = 0; b < 2; b++)
      begin
         wr(CTRL_OFS, 32'h4D | 32'(b << 4));
         wr(HOLD_OFS, 32'h55);
         wait_idle;
         frame({1'b1, b[0], 8'h55});
      end
      rx_nine <= 1'b0;
      wr(CTRL_OFS, 32'h65);
      rx_inv <= 1'b1;
      settle;
      check({31'h0, tx_out}, 32'h0);
      wr(HOLD_OFS, 32'h0F);
      wait_idle;
      frame(10'h20F);
      wr(CTRL_OFS, 32'h45);
      rx_inv <= 1'b0;
      settle;
      wr(CTRL_OFS, 32'hC5);
      wr(HOLD_OFS, 32'h0);
      n = 0;
      while (tx_out !== 1'b0) @(posedge hclk);
      while (tx_out === 1'b0)
      begin
         n++;
         @(posedge hclk);
      end
      check(n, 32'(BREAK_BITS * 3));
      wait_idle;
      rdchk(CTRL_OFS, 32'h45);
      settle;
      wr(CTRL_OFS, 32'h47);
      wr(HOLD_OFS, 32'h99);
      repeat (60) @(posedge hclk);
      check(i_serial_rx_model.got.size(), 32'h0);
      check({31'h0, tx_out}, 32'h1);
      wr(CTRL_OFS, 32'h45);
      repeat (4) @(posedge hclk);
      wait_idle;
      frame(10'h299);
      wr(CTRL_OFS, 32'h44);
      repeat (2) @(posedge hclk);
      check({31'h0, tx_oe}, 32'h0);
      test_done;
   end
endmodule : testbench
`default_nettype wire
